/* File: hw/tw_pkg.sv */
// Constants and types of the two-wire controller
package tw_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h04;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int QUARTER_NS = 2500;
  localparam int QUARTER_CYC = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic mstr;
    logic cont;
    logic xmit;
    logic ack;
    logic addr;
    logic arb;
    logic rstop;
    logic en;
  } tw_ctrl_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } tw_line_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BITS = 3'b011,
    ST_ACK = 3'b010,
    ST_HOLD = 3'b110,
    ST_STOP = 3'b111,
    ST_RSTART = 3'b101,
    ST_WAITSTOP = 3'b100
  } tw_state_e;
endpackage : tw_pkg

/* File: hw/tw_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module tw_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '1;
      q <= '1;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : tw_sync

/* File: hw/tw_tick.sv */
// Divider giving one quarter-bit enable pulse
`timescale 1ns/10ps
module tw_tick #(
  parameter int CYC = tw_pkg::QUARTER_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic tick
);
  logic [15:0] cnt_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end
    else if (cnt_reg == 16'(CYC - 1))
    begin
      cnt_reg <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule : tw_tick

/* File: hw/tw_ctrl.sv */
// Two-wire master/slave controller with AHB-Lite registers
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module tw_ctrl #(
  parameter int QUARTER = tw_pkg::QUARTER_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic PIN_TAKEOVER,
  output logic TW_IRQ
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  tw_pkg::tw_ctrl_s ctrl_reg;
  tw_pkg::tw_ctrl_s w;
  tw_pkg::tw_line_s ln;
  tw_pkg::tw_line_s ln_d_reg;
  tw_pkg::tw_state_e st_reg;
  logic a_wr_reg;
  logic [7:0] a_ofs_reg;
  logic [31:0] rdata_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic tick;
  logic wr_ctrl;
  logic wr_ok;
  logic go_start;
  logic go_stop;
  logic go_rs;
  logic go_cont;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic adv;
  logic bus_busy_reg;
  logic start_pend_reg;
  logic [1:0] q_reg;
  logic [2:0] bit_reg;
  logic [7:0] sh_reg;
  logic role_m_reg;
  logic tx_mode_reg;
  logic ackdue_reg;
  logic nack_reg;
  logic arb_pend_reg;
  logic scl_low_reg;
  logic sda_low_reg;
  logic ev_byte_reg;
  logic ev_ack_reg;
  logic ack_val_reg;
  logic ev_arb_reg;
  logic ev_addr_reg;
  logic ev_stop_reg;
  logic rs_clr_reg;
  logic ev_done_reg;

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_reg;

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      a_wr_reg <= 1'b0;
      a_ofs_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end
    else if (HREADY)
    begin
      a_wr_reg <= HSEL & HTRANS[1] & HWRITE;
      a_ofs_reg <= HADDR[7:0];
      rdata_reg <= 32'h0000_0000;
      if (HSEL && HTRANS[1] && !HWRITE)
      begin
        if (HADDR[7:0] == tw_pkg::CTRL_OFS)
          rdata_reg <= {24'h00_0000, ctrl_reg};
        else if (HADDR[7:0] == tw_pkg::DATA_OFS)
          rdata_reg <= {24'h00_0000, rx_reg};
      end
    end
  end

  // Transmit byte register, separate from the received byte
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      tx_reg <= tw_pkg::DATA_RST;
    else if (a_wr_reg && a_ofs_reg == tw_pkg::DATA_OFS)
      tx_reg <= HWDATA[7:0];
  end

  // ---------------------------------------------------------------
  // Control write decode
  // ---------------------------------------------------------------
  assign w = tw_pkg::tw_ctrl_s'(HWDATA[7:0]);
  assign wr_ctrl = a_wr_reg && a_ofs_reg == tw_pkg::CTRL_OFS;
  assign wr_ok = wr_ctrl && !ctrl_reg.cont;
  assign go_start = wr_ok && w.en && w.mstr && !ctrl_reg.mstr;
  assign go_stop = wr_ok && !w.mstr && ctrl_reg.mstr;
  assign go_rs = wr_ok && w.mstr && ctrl_reg.mstr && w.cont && w.arb;
  assign go_cont = wr_ok && w.cont && w.mstr == ctrl_reg.mstr && !go_rs;

  // ---------------------------------------------------------------
  // Status and control register; hardware sets win
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      ctrl_reg <= tw_pkg::tw_ctrl_s'(tw_pkg::CTRL_RST);
    else
    begin
      if (wr_ok)
      begin
        ctrl_reg.en <= w.en;
        ctrl_reg.mstr <= w.mstr;
        ctrl_reg.xmit <= w.xmit;
        ctrl_reg.ack <= w.ack;
        ctrl_reg.cont <= w.cont | go_start;
        ctrl_reg.addr <= ctrl_reg.addr & w.addr & ~w.cont;
        ctrl_reg.arb <= w.arb;
        ctrl_reg.rstop <= ctrl_reg.rstop & w.rstop;
      end
      if (ev_byte_reg)
        ctrl_reg.cont <= 1'b0;
      // Byte ended quietly: not busy, no interrupt
      if (ev_done_reg)
        ctrl_reg.cont <= 1'b0;
      if (ev_ack_reg)
        ctrl_reg.ack <= ack_val_reg;
      if (rs_clr_reg)
        ctrl_reg.arb <= 1'b0;
      if (ev_addr_reg)
      begin
        ctrl_reg.addr <= 1'b1;
        ctrl_reg.cont <= 1'b1;
      end
      if (ev_stop_reg)
      begin
        ctrl_reg.rstop <= 1'b1;
        ctrl_reg.cont <= 1'b0;
      end
      if (ev_arb_reg)
      begin
        ctrl_reg.mstr <= 1'b0;
        ctrl_reg.arb <= 1'b1;
        ctrl_reg.addr <= 1'b1;
        ctrl_reg.cont <= 1'b0;
      end
    end
  end

  // One interrupt pulse per byte, stop or lost-arbitration event
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      TW_IRQ <= 1'b0;
    else
      TW_IRQ <= ev_byte_reg | ev_stop_reg | ev_arb_reg;
  end

  // ---------------------------------------------------------------
  // Line sampling and bus conditions
  // ---------------------------------------------------------------
  tw_sync #(
    .W(2)
  ) u_sync (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .d({SCL_IN, SDA_IN}),
    .q(ln)
  );

  tw_tick #(
    .CYC(QUARTER)
  ) u_tick (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .tick(tick)
  );

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      ln_d_reg <= 2'b11;
    else
      ln_d_reg <= ln;
  end

  assign scl_rise = ln.scl & ~ln_d_reg.scl;
  assign scl_fall = ~ln.scl & ln_d_reg.scl;
  assign start_det = ln_d_reg.sda & ~ln.sda & ln.scl & ln_d_reg.scl;
  assign stop_det = ~ln_d_reg.sda & ln.sda & ln.scl & ln_d_reg.scl;

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      bus_busy_reg <= 1'b0;
    else if (start_det)
      bus_busy_reg <= 1'b1;
    else if (stop_det)
      bus_busy_reg <= 1'b0;
  end

  // Quarter step stalls while a stretched clock stays low
  assign adv = tick && !(q_reg == 2'd1 && !ln.scl);

  // ---------------------------------------------------------------
  // Pins: open drain, low only
  // ---------------------------------------------------------------
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE = scl_low_reg;
  assign SDA_OE = sda_low_reg;
  assign PIN_TAKEOVER = ctrl_reg.en;

  // ---------------------------------------------------------------
  // Byte engine
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_reg <= tw_pkg::ST_IDLE;
      q_reg <= 2'd0;
      bit_reg <= 3'd7;
      sh_reg <= 8'h00;
      rx_reg <= 8'h00;
      role_m_reg <= 1'b0;
      tx_mode_reg <= 1'b0;
      ackdue_reg <= 1'b0;
      nack_reg <= 1'b0;
      arb_pend_reg <= 1'b0;
      start_pend_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      ev_byte_reg <= 1'b0;
      ev_ack_reg <= 1'b0;
      ack_val_reg <= 1'b0;
      ev_arb_reg <= 1'b0;
      ev_addr_reg <= 1'b0;
      ev_stop_reg <= 1'b0;
      rs_clr_reg <= 1'b0;
      ev_done_reg <= 1'b0;
    end
    else
    begin
      ev_byte_reg <= 1'b0;
      ev_ack_reg <= 1'b0;
      ev_arb_reg <= 1'b0;
      ev_addr_reg <= 1'b0;
      ev_stop_reg <= 1'b0;
      rs_clr_reg <= 1'b0;
      ev_done_reg <= 1'b0;
      if (go_start)
        start_pend_reg <= 1'b1;
      if (!ctrl_reg.en)
      begin
        st_reg <= tw_pkg::ST_IDLE;
        scl_low_reg <= 1'b0;
        sda_low_reg <= 1'b0;
        start_pend_reg <= 1'b0;
        arb_pend_reg <= 1'b0;
      end
      else if (!role_m_reg && st_reg != tw_pkg::ST_IDLE && start_det)
      begin
        // Repeated start seen as slave
        st_reg <= tw_pkg::ST_BITS;
        bit_reg <= 3'd7;
        tx_mode_reg <= 1'b0;
        nack_reg <= 1'b0;
        scl_low_reg <= 1'b0;
        sda_low_reg <= 1'b0;
        ev_addr_reg <= ~arb_pend_reg;
      end
      else if (!role_m_reg && st_reg != tw_pkg::ST_IDLE && stop_det)
      begin
        st_reg <= tw_pkg::ST_IDLE;
        sda_low_reg <= 1'b0;
        arb_pend_reg <= 1'b0;
        ev_done_reg <= 1'b1;
        ev_arb_reg <= arb_pend_reg;
        ev_stop_reg <= ~arb_pend_reg & ~tx_mode_reg & ~nack_reg;
      end
      else
      begin
        unique case (st_reg)
          tw_pkg::ST_IDLE:
          begin
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            if (start_pend_reg && !bus_busy_reg)
            begin
              start_pend_reg <= 1'b0;
              role_m_reg <= 1'b1;
              nack_reg <= 1'b0;
              st_reg <= tw_pkg::ST_START;
              q_reg <= 2'd0;
            end
            else if (start_det)
            begin
              role_m_reg <= 1'b0;
              st_reg <= tw_pkg::ST_BITS;
              bit_reg <= 3'd7;
              tx_mode_reg <= 1'b0;
              nack_reg <= 1'b0;
              ev_addr_reg <= 1'b1;
            end
          end
          tw_pkg::ST_START:
          begin
            if (adv)
            begin
              q_reg <= q_reg + 2'd1;
              if (q_reg == 2'd0)
                sda_low_reg <= 1'b1;
              if (q_reg == 2'd2)
                scl_low_reg <= 1'b1;
              if (q_reg == 2'd3)
              begin
                sh_reg <= tx_reg;
                sda_low_reg <= ~tx_reg[7];
                tx_mode_reg <= 1'b1;
                bit_reg <= 3'd7;
                st_reg <= tw_pkg::ST_BITS;
              end
            end
          end
          tw_pkg::ST_RSTART:
          begin
            if (adv)
            begin
              q_reg <= q_reg + 2'd1;
              if (q_reg == 2'd0)
                scl_low_reg <= 1'b0;
              if (q_reg == 2'd1)
              begin
                sda_low_reg <= 1'b1;
                rs_clr_reg <= 1'b1;
              end
              if (q_reg == 2'd2)
                scl_low_reg <= 1'b1;
              if (q_reg == 2'd3)
              begin
                sh_reg <= tx_reg;
                sda_low_reg <= ~tx_reg[7];
                tx_mode_reg <= 1'b1;
                bit_reg <= 3'd7;
                st_reg <= tw_pkg::ST_BITS;
              end
            end
          end
          tw_pkg::ST_BITS:
          begin
            if (role_m_reg && adv)
            begin
              q_reg <= q_reg + 2'd1;
              unique case (q_reg)
                2'd0: scl_low_reg <= 1'b0;
                2'd1:
                begin
                  sh_reg <= {sh_reg[6:0], ln.sda};
                  if (tx_mode_reg && sh_reg[7] && !ln.sda)
                  begin
                    // Lost: drop out, report once the bus is free
                    role_m_reg <= 1'b0;
                    arb_pend_reg <= 1'b1;
                    sda_low_reg <= 1'b0;
                    st_reg <= tw_pkg::ST_WAITSTOP;
                  end
                end
                2'd2: scl_low_reg <= 1'b1;
                2'd3:
                begin
                  if (bit_reg == 3'd0)
                  begin
                    sda_low_reg <= 1'b0;
                    if (tx_mode_reg)
                      st_reg <= tw_pkg::ST_ACK;
                    else
                    begin
                      rx_reg <= sh_reg;
                      ackdue_reg <= 1'b1;
                      ev_byte_reg <= 1'b1;
                      st_reg <= tw_pkg::ST_HOLD;
                    end
                  end
                  else
                  begin
                    bit_reg <= bit_reg - 3'd1;
                    sda_low_reg <= tx_mode_reg & ~sh_reg[7];
                  end
                end
              endcase
            end
            else if (!role_m_reg && scl_rise)
              sh_reg <= {sh_reg[6:0], ln.sda};
            else if (!role_m_reg && scl_fall)
            begin
              if (bit_reg == 3'd0)
              begin
                sda_low_reg <= 1'b0;
                if (tx_mode_reg)
                  st_reg <= tw_pkg::ST_ACK;
                else
                begin
                  rx_reg <= sh_reg;
                  ackdue_reg <= 1'b1;
                  scl_low_reg <= 1'b1;
                  ev_byte_reg <= 1'b1;
                  st_reg <= tw_pkg::ST_HOLD;
                end
              end
              else
              begin
                bit_reg <= bit_reg - 3'd1;
                sda_low_reg <= tx_mode_reg & ~sh_reg[7];
              end
            end
          end
          tw_pkg::ST_ACK:
          begin
            if (role_m_reg && adv)
            begin
              q_reg <= q_reg + 2'd1;
              if (q_reg == 2'd0)
                scl_low_reg <= 1'b0;
              if (q_reg == 2'd1 && tx_mode_reg)
              begin
                ev_ack_reg <= 1'b1;
                ack_val_reg <= ~ln.sda;
              end
              if (q_reg == 2'd2)
                scl_low_reg <= 1'b1;
              if (q_reg == 2'd3)
              begin
                sda_low_reg <= 1'b0;
                bit_reg <= 3'd7;
                if (tx_mode_reg)
                begin
                  ev_byte_reg <= 1'b1;
                  st_reg <= tw_pkg::ST_HOLD;
                end
                else
                begin
                  ev_done_reg <= nack_reg;
                  st_reg <= nack_reg ? tw_pkg::ST_HOLD : tw_pkg::ST_BITS;
                end
              end
            end
            else if (!role_m_reg && scl_rise && tx_mode_reg)
            begin
              ev_ack_reg <= 1'b1;
              ack_val_reg <= ~ln.sda;
            end
            else if (!role_m_reg && scl_fall)
            begin
              bit_reg <= 3'd7;
              sda_low_reg <= 1'b0;
              if (tx_mode_reg)
              begin
                scl_low_reg <= 1'b1;
                ev_byte_reg <= 1'b1;
                st_reg <= tw_pkg::ST_HOLD;
              end
              else if (nack_reg)
                st_reg <= tw_pkg::ST_WAITSTOP;
              else if (ctrl_reg.xmit)
              begin
                tx_mode_reg <= 1'b1;
                sh_reg <= tx_reg;
                sda_low_reg <= ~tx_reg[7];
                st_reg <= tw_pkg::ST_BITS;
              end
              else
                st_reg <= tw_pkg::ST_BITS;
            end
          end
          tw_pkg::ST_HOLD:
          begin
            q_reg <= 2'd0;
            bit_reg <= 3'd7;
            if (go_stop && role_m_reg)
            begin
              sda_low_reg <= 1'b1;
              st_reg <= tw_pkg::ST_STOP;
            end
            else if (go_rs && role_m_reg)
            begin
              sda_low_reg <= 1'b0;
              nack_reg <= 1'b0;
              st_reg <= tw_pkg::ST_RSTART;
            end
            else if (go_cont && ackdue_reg)
            begin
              ackdue_reg <= 1'b0;
              tx_mode_reg <= 1'b0;
              nack_reg <= ~w.ack;
              sda_low_reg <= w.ack;
              scl_low_reg <= role_m_reg;
              st_reg <= tw_pkg::ST_ACK;
            end
            else if (go_cont && !nack_reg)
            begin
              tx_mode_reg <= w.xmit;
              sh_reg <= tx_reg;
              sda_low_reg <= w.xmit & ~tx_reg[7];
              scl_low_reg <= role_m_reg;
              st_reg <= tw_pkg::ST_BITS;
            end
          end
          tw_pkg::ST_STOP:
          begin
            if (adv)
            begin
              q_reg <= q_reg + 2'd1;
              if (q_reg == 2'd0)
                scl_low_reg <= 1'b0;
              if (q_reg == 2'd2)
                sda_low_reg <= 1'b0;
              if (q_reg == 2'd3)
              begin
                role_m_reg <= 1'b0;
                st_reg <= tw_pkg::ST_IDLE;
              end
            end
          end
          tw_pkg::ST_WAITSTOP:
          begin
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule : tw_ctrl

/* File: tb/tw_ctrl_checker.sv */
// Port assertions of the two-wire controller
`timescale 1ns/10ps
module tw_ctrl_checker (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [31:0] HRDATA,
  input wire logic SCL_IN,
  input wire logic SCL_OUT,
  input wire logic SCL_OE,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic PIN_TAKEOVER,
  input wire logic TW_IRQ
);
  // ----------------
  // Assertions
  // ----------------
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);
  sequence s_held;
    SCL_OE [*3];
  endsequence
  sequence s_stretched;
    $fell(SCL_OE) ##1 !SCL_IN;
  endsequence
  AST_OPEN_DRAIN: assert property (!SCL_OUT && !SDA_OUT)
    else $error("pin driven high");
  AST_OWN_PINS: assert property ((SCL_OE || SDA_OE) |-> PIN_TAKEOVER)
    else $error("line pulled without takeover");
  AST_IRQ_PULSE: assert property (TW_IRQ |=> !TW_IRQ)
    else $error("interrupt longer than one cycle");
  AST_HOLD_IRQ: assert property (TW_IRQ && SCL_OE |-> s_held)
    else $error("clock released before firmware answered");
  AST_CLK_LOW_MIN: assert property ($rose(SCL_OE) |-> SCL_OE [*4])
    else $error("clock low phase too short");
  AST_CLK_SYNC: assert property (s_stretched |=> !SCL_OE [*3])
    else $error("clock pulled during stretch");
  AST_STOP_FORM: assert property ($fell(SDA_OE) && !SCL_OE && PIN_TAKEOVER |->
    !$past(SCL_OE, 2))
    else $error("data released with clock just released");
  AST_UPPER_ZERO: assert property (HRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule : tw_ctrl_checker

/* File: tb/tw_slave_model.sv */
// Behavioural target device on the two-wire bus
`timescale 1ns/10ps
module tw_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic slow,
  output logic scl_low,
  output logic sda_low
);
  logic [7:0] sh = 8'h0, rx = 8'h0, tx = 8'ha5;
  logic act = 1'h0, hit = 1'h0, rdm = 1'h0, first = 1'h0, mack = 1'h0;
  int n = 0, stops = 0;
  initial
  begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end
  always @(negedge sda)
    if (scl)
    begin
      act = 1'h1;
      first = 1'h1;
      n = -1;
    end
  always @(posedge sda)
    if (scl && act)
    begin
      act = 1'h0;
      stops++;
    end
  always @(negedge scl)
    if (act)
    begin
      first = first && n != 8;
      n = (n == 8) ? 0 : n + 1;
      sda_low = 1'h0;
      if (n == 8 && first)
      begin
        hit = sh[7:1] == ADDR;
        rdm = sh[0];
      end
      if (n == 8 && hit && !(rdm && !first))
        sda_low = 1'h1;
      if (n < 8 && hit && rdm && !first)
        sda_low = !tx[7-n];
      if (n == 8 && hit && rdm && !first)
        tx = ~tx;
      // Stretch the low phase when asked
      if (slow)
      begin
        scl_low = 1'h1;
        #200;
        scl_low = 1'h0;
      end
    end
  always @(posedge scl)
    if (act && n >= 0 && n < 8)
      sh = {sh[6:0], sda};
    else if (act && n == 8 && hit && rdm && !first)
    begin
      mack = !sda;
      hit = !sda;
    end
    else if (act && n == 8)
      rx = sh;
endmodule : tw_slave_model

/* File: tb/tw_ctrl_test.sv */
// Self-checking bench of the two-wire controller
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module tw_ctrl_test;
  localparam logic [6:0] SLV = 7'h2a;
  logic clk = 1'h0, rst_b = 1'h0, hsel = 1'h0, hwrite = 1'h0, slow = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hready, hresp, scl_oe, sda_oe, sl_scl, sl_sda, own, irq;
  wire scl = !(scl_oe | sl_scl);
  wire sda = !(sda_oe | sl_sda);
  int n_errors = 0, checks = 0, i;
  always #2 clk = ~clk;
  tw_ctrl #(.QUARTER(2)) u_dut (.REF_CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .SCL_IN(scl), .SCL_OUT(),
    .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .PIN_TAKEOVER(own),
    .TW_IRQ(irq));
  tw_slave_model #(.ADDR(SLV)) u_sl (.scl(scl), .sda(sda), .slow(slow), .scl_low(sl_scl),
    .sda_low(sl_sda));
  // ----------------
  // Bus tasks
  // ----------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 8'h0);
    `CHK(rd, e)
  endtask : rdc
  task automatic wirq;
    for (i = 0; i < 4000 && irq !== 1'h1; i++)
      @(negedge clk);
    `CHK(irq, 1'h1)
    @(posedge clk);
  endtask : wirq
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // ----------------
  // Tests
  // ----------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rdc(8'h00, 32'h0);
    `CHK(hresp, 1'h0)
    rdc(8'h04, 32'h0);
    bus(1'h1, 8'h08, 8'hff);
    rdc(8'h08, 32'h0);
    bus(1'h1, 8'h00, 8'h01);
    rdc(8'h00, 32'h01);
    `CHK(own, 1'h1)
    bus(1'h1, 8'h04, {SLV, 1'h0});
    bus(1'h1, 8'h00, 8'h81);
    rdc(8'h00, 32'hc1);
    bus(1'h1, 8'h00, 8'h01);
    wirq;
    `CHK(scl_oe, 1'h1)
    rdc(8'h00, 32'h91);
    `CHK(u_sl.rx, {SLV, 1'h0})
    slow <= 1'h1;
    bus(1'h1, 8'h04, 8'h3c);
    rdc(8'h04, 32'h0);
    bus(1'h1, 8'h00, 8'he1);
    wirq;
    slow <= 1'h0;
    rdc(8'h00, 32'hb1);
    `CHK(u_sl.rx, 8'h3c)
    bus(1'h1, 8'h04, 8'hfe);
    bus(1'h1, 8'h00, 8'hc5);
    wirq;
    rdc(8'h00, 32'h81);
    bus(1'h1, 8'h04, {SLV, 1'h1});
    bus(1'h1, 8'h00, 8'hc5);
    wirq;
    rdc(8'h00, 32'h91);
    bus(1'h1, 8'h00, 8'hc1);
    wirq;
    rdc(8'h04, 32'ha5);
    bus(1'h1, 8'h00, 8'hd1);
    wirq;
    `CHK(u_sl.mack, 1'h1)
    rdc(8'h04, 32'h5a);
    bus(1'h1, 8'h00, 8'hc1);
    bus(1'h0, 8'h00, 8'h0);
    for (i = 0; i < 300 && rd[6] !== 1'h0; i++)
      bus(1'h0, 8'h00, 8'h0);
    `CHK(rd[7:0], 8'h81)
    `CHK(u_sl.mack, 1'h0)
    bus(1'h1, 8'h00, 8'h01);
    for (i = 0; i < 300 && u_sl.stops == 0; i++)
      @(posedge clk);
    `CHK(u_sl.stops, 1)
    `CHK(scl_oe | sda_oe, 1'h0)
    rdc(8'h00, 32'h01);
    bus(1'h1, 8'h00, 8'h00);
    rdc(8'h00, 32'h0);
    `CHK(own, 1'h0)
    complete_run;
  end
  // Far above the expected run of one to two thousand cycles
  initial
  begin
    #200000;
    n_errors++;
    complete_run;
  end
endmodule : tw_ctrl_test
bind tw_ctrl tw_ctrl_checker u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .HRDATA(HRDATA),
  .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .PIN_TAKEOVER(PIN_TAKEOVER), .TW_IRQ(TW_IRQ));
